// >>> logic/gsei_top.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
// pin levels and edge interrupt behind an axi4-lite slave, revision reply on the byte exchange port
module gsei_top #(
  parameter logic [15:0] REV_CODE = 16'h0210 // arbitrary revision value
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire gsei_pkg::gsei_axi_req_t axi_req,
  output gsei_pkg::gsei_axi_rsp_t      axi_rsp,
  input  wire logic [7:0]              pin_level_bits_in,
  output logic      [7:0]              pin_level_bits_out,
  input  wire logic                    edge_sense_pin,
  input  wire logic                    xfer_valid,
  input  wire logic [7:0]              xfer_byte_in,
  output logic      [7:0]              xfer_byte_out,
  output logic                         irq
);

  // index decode of a byte address; misaligned words never hit
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] idx);
    hit = (addr[1:0] == 2'h0) && ({2'h0, addr[7:2]} == idx);
  endfunction : hit

  // write channel capture
  logic        aw_have_ff;   // address held, waiting for data
  logic [7:0]  awaddr_ff;
  logic        w_have_ff;    // data held, waiting for address
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;

  // registers
  logic [7:0]  pin_out_ff;   // driven pin levels
  logic [2:0]  edge_ctrl_ff; // flag, allow, polarity
  logic [1:0]  irq_stat_ff;  // sticky events
  logic [1:0]  irq_en_ff;

  // synchronisers: stage one is read only by stage two
  logic [7:0]  pin_s1_ff;
  logic [7:0]  pin_s2_ff;
  logic        esp_s1_ff;
  logic        esp_s2_ff;
  logic        esp_old_ff;   // previous synced level for edge compare

  // handshake wires
  wire aw_hs = axi_req.awvalid && axi_rsp.awready;
  wire w_hs  = axi_req.wvalid && axi_rsp.wready;
  wire ar_hs = axi_req.arvalid && axi_rsp.arready;

  // write commits once both halves are present and no response is pending
  wire         aw_ok   = aw_have_ff || aw_hs;
  wire         w_ok    = w_have_ff || w_hs;
  wire         wr_fire = aw_ok && w_ok && !bvalid_ff;
  wire [7:0]   wr_addr = aw_have_ff ? awaddr_ff : axi_req.awaddr;
  wire [31:0]  wr_data = w_have_ff ? wdata_ff : axi_req.wdata;
  wire [3:0]   wr_strb = w_have_ff ? wstrb_ff : axi_req.wstrb;
  wire         wr_lane = wr_fire && wr_strb[0]; // registers live in lane 0

  // write decode
  wire wr_pin_hit  = hit(wr_addr, gsei_pkg::IDX_PIN_LEVELS);
  wire wr_edge_hit = hit(wr_addr, gsei_pkg::IDX_EDGE_CTRL);
  wire wr_stat_hit = hit(wr_addr, gsei_pkg::IDX_IRQ_STATUS);
  wire wr_en_hit   = hit(wr_addr, gsei_pkg::IDX_IRQ_ENABLE);
  wire wr_clr_hit  = hit(wr_addr, gsei_pkg::IDX_IRQ_CLEAR);
  wire wr_mapped   = wr_pin_hit || wr_edge_hit || wr_stat_hit || wr_en_hit || wr_clr_hit;

  // read decode
  wire rd_pin_hit  = hit(axi_req.araddr, gsei_pkg::IDX_PIN_LEVELS);
  wire rd_edge_hit = hit(axi_req.araddr, gsei_pkg::IDX_EDGE_CTRL);
  wire rd_stat_hit = hit(axi_req.araddr, gsei_pkg::IDX_IRQ_STATUS);
  wire rd_en_hit   = hit(axi_req.araddr, gsei_pkg::IDX_IRQ_ENABLE);
  wire rd_clr_hit  = hit(axi_req.araddr, gsei_pkg::IDX_IRQ_CLEAR);
  wire rd_mapped   = rd_pin_hit || rd_edge_hit || rd_stat_hit || rd_en_hit || rd_clr_hit;

  // edge register image; bits 4..0 read as zero
  wire [7:0] edge_image = {edge_ctrl_ff, 5'h00};

  // read data select; the clear register is write-only and reads zero
  wire [7:0] rd_byte = rd_pin_hit  ? pin_s2_ff :
                       rd_edge_hit ? edge_image :
                       rd_stat_hit ? {6'h00, irq_stat_ff} :
                       rd_en_hit   ? {6'h00, irq_en_ff} : 8'h00;

  // qualifying edge on the synced sense pin
  wire rise     = esp_s2_ff && !esp_old_ff;
  wire fall     = !esp_s2_ff && esp_old_ff;
  wire pol_fall = edge_ctrl_ff[gsei_pkg::EDGE_POL_BIT - 5];
  wire edge_ev  = pol_fall ? fall : rise;

  // edge control next value: hardware set beats a software clear
  wire       flag_clr   = wr_lane && wr_edge_hit && !wr_data[gsei_pkg::EDGE_FLAG_BIT];
  wire       nxt_flag   = (edge_ctrl_ff[2] && !flag_clr) || edge_ev;
  wire [1:0] nxt_ctl_lo = (wr_lane && wr_edge_hit) ?
                          wr_data[gsei_pkg::EDGE_ALLOW_BIT:gsei_pkg::EDGE_POL_BIT] : edge_ctrl_ff[1:0];

  // interrupt events; the edge only counts while allowed
  logic      rev_done;
  wire       allow    = edge_ctrl_ff[gsei_pkg::EDGE_ALLOW_BIT - 5];
  wire [1:0] irq_ev   = {rev_done, edge_ev && allow};
  wire [1:0] irq_clr  = (wr_lane && wr_clr_hit) ? wr_data[1:0] : 2'h0;
  wire [1:0] nxt_stat = (irq_stat_ff & ~irq_clr) | irq_ev;

  // bus outputs; ready drops while a channel's word is held or a reply waits
  assign axi_rsp.awready = !aw_have_ff && !bvalid_ff;
  assign axi_rsp.wready  = !w_have_ff && !bvalid_ff;
  assign axi_rsp.bvalid  = bvalid_ff;
  assign axi_rsp.bresp   = bresp_ff;
  assign axi_rsp.arready = !rvalid_ff;
  assign axi_rsp.rvalid  = rvalid_ff;
  assign axi_rsp.rdata   = rdata_ff;
  assign axi_rsp.rresp   = rresp_ff;

  assign pin_level_bits_out = pin_out_ff;
  assign irq                = |(irq_stat_ff & irq_en_ff);

  // input synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_ff  <= 8'h00;
      pin_s2_ff  <= 8'h00;
      esp_s1_ff  <= 1'b0;
      esp_s2_ff  <= 1'b0;
      esp_old_ff <= 1'b0;
    end else begin
      pin_s1_ff  <= pin_level_bits_in;
      pin_s2_ff  <= pin_s1_ff;
      esp_s1_ff  <= edge_sense_pin;
      esp_s2_ff  <= esp_s1_ff;
      esp_old_ff <= esp_s2_ff;
    end
  end

  // write address and data holding; either may arrive first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
    end else begin
      aw_have_ff <= aw_ok && !wr_fire;
      w_have_ff  <= w_ok && !wr_fire;
      if (aw_hs) begin
        awaddr_ff <= axi_req.awaddr;
      end
      if (w_hs) begin
        wdata_ff <= axi_req.wdata;
        wstrb_ff <= axi_req.wstrb;
      end
    end
  end

  // write and read responses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= gsei_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= gsei_pkg::RESP_OKAY;
    end else begin
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_mapped ? gsei_pkg::RESP_OKAY : gsei_pkg::RESP_DECERR;
      end else if (axi_req.bready) begin
        bvalid_ff <= 1'b0;
      end
      if (ar_hs) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= {24'h000000, rd_byte};
        rresp_ff  <= rd_mapped ? gsei_pkg::RESP_OKAY : gsei_pkg::RESP_DECERR;
      end else if (axi_req.rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // software registers and sticky status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_ff   <= gsei_pkg::RST_PIN_LEVELS;
      edge_ctrl_ff <= gsei_pkg::RST_EDGE_CTRL[7:5];
      irq_stat_ff  <= gsei_pkg::RST_IRQ;
      irq_en_ff    <= gsei_pkg::RST_IRQ;
    end else begin
      if (wr_lane && wr_pin_hit) begin
        pin_out_ff <= wr_data[7:0];
      end
      edge_ctrl_ff <= {nxt_flag, nxt_ctl_lo};
      irq_stat_ff  <= nxt_stat;
      if (wr_lane && wr_en_hit) begin
        irq_en_ff <= wr_data[1:0];
      end
    end
  end

  // revision responder on the byte exchange port
  gsei_rev_reply #(
    .REV_CODE (REV_CODE)
  ) u_rev (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .xfer_valid   (xfer_valid),
    .xfer_byte_in (xfer_byte_in),
    .reply_byte   (xfer_byte_out),
    .rev_done     (rev_done)
  );

endmodule : gsei_top

// >>> pkg/gsei_pkg.sv
// Behaviour
// - pin-level register at 0x01, resets 0x00, drives pins
// - bit 7 flags a seen qualifying edge
// - bit 6 gates edge into interrupt
// - edge register at 0x08, resets 0x00
// - device returns two BCD bytes, MSB first
package gsei_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PIN_LEVELS = 8'h01;
  localparam logic [7:0] IDX_EDGE_CTRL  = 8'h08;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h11;
  localparam logic [7:0] IDX_IRQ_CLEAR  = 8'h12;

  // reset values
  localparam logic [7:0] RST_PIN_LEVELS = 8'h00;
  localparam logic [7:0] RST_EDGE_CTRL  = 8'h00;
  localparam logic [1:0] RST_IRQ        = 2'h0;

  // edge control field positions
  localparam int unsigned EDGE_FLAG_BIT  = 7;
  localparam int unsigned EDGE_ALLOW_BIT = 6;
  localparam int unsigned EDGE_POL_BIT   = 5;

  // interrupt status bit positions
  localparam int unsigned IRQ_EDGE_BIT = 0;
  localparam int unsigned IRQ_REV_BIT  = 1;

  // revision command byte
  localparam logic [7:0] REV_CMD_BYTE = 8'h40;
  localparam logic [7:0] IDLE_REPLY   = 8'h00;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // bus inputs from the master
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } gsei_axi_req_t;

  // bus outputs to the master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } gsei_axi_rsp_t;

  // revision reply sequence
  typedef enum logic [1:0] {
    REV_IDLE,
    REV_DUMMY,
    REV_HIGH,
    REV_LOW
  } gsei_rev_state_t;

endpackage : gsei_pkg

// >>> logic/gsei_rev_reply.sv
`timescale 1ns/1ps
// full-duplex byte responder: each exchange takes one host byte and
// presents the byte that goes out on the following exchange
module gsei_rev_reply #(
  parameter logic [15:0] REV_CODE = 16'h0210
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       xfer_valid,
  input  wire logic [7:0] xfer_byte_in,
  output logic      [7:0] reply_byte,
  output logic            rev_done
);

  gsei_pkg::gsei_rev_state_t state_ff;      // position in the sequence
  gsei_pkg::gsei_rev_state_t nxt_state;
  logic [7:0]                reply_ff;      // byte for the next exchange
  logic [7:0]                nxt_reply;
  logic                      done_ff;       // one-cycle end pulse
  logic                      is_cmd;

  assign is_cmd     = (xfer_byte_in == gsei_pkg::REV_CMD_BYTE);
  assign reply_byte = reply_ff;
  assign rev_done   = done_ff;

  // sequence decode; only moves on an exchange
  always_comb begin
    nxt_state = state_ff;
    nxt_reply = reply_ff;
    if (xfer_valid) begin
      unique case (state_ff)
        gsei_pkg::REV_IDLE: begin
          // command seen: the dummy exchange still returns filler
          nxt_state = is_cmd ? gsei_pkg::REV_DUMMY : gsei_pkg::REV_IDLE;
          nxt_reply = gsei_pkg::IDLE_REPLY;
        end
        gsei_pkg::REV_DUMMY: begin
          // dummy byte content is ignored by design
          nxt_state = gsei_pkg::REV_HIGH;
          nxt_reply = REV_CODE[15:8];
        end
        gsei_pkg::REV_HIGH: begin
          nxt_state = gsei_pkg::REV_LOW;
          nxt_reply = REV_CODE[7:0];
        end
        gsei_pkg::REV_LOW: begin
          // a command in the last slot restarts at once
          nxt_state = is_cmd ? gsei_pkg::REV_DUMMY : gsei_pkg::REV_IDLE;
          nxt_reply = gsei_pkg::IDLE_REPLY;
        end
      endcase
    end
  end

  // state, reply byte and done pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= gsei_pkg::REV_IDLE;
      reply_ff <= gsei_pkg::IDLE_REPLY;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      reply_ff <= nxt_reply;
      done_ff  <= xfer_valid && (state_ff == gsei_pkg::REV_LOW);
    end
  end

endmodule : gsei_rev_reply

// >>> tb/gsei_monitor.sv
`timescale 1ns/1ps
// port-side watcher for pin levels, edge interrupt and revision reply
module gsei_monitor #(
  parameter logic [15:0] REV_CODE = 16'h0210 // arbitrary revision value
) (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire gsei_pkg::gsei_axi_req_t axi_req,
  input wire gsei_pkg::gsei_axi_rsp_t axi_rsp,
  input wire logic [7:0]              pin_level_bits_in,
  input wire logic [7:0]              pin_level_bits_out,
  input wire logic                    edge_sense_pin,
  input wire logic                    xfer_valid,
  input wire logic [7:0]              xfer_byte_in,
  input wire logic [7:0]              xfer_byte_out,
  input wire logic                    irq
);
  logic [7:0] ar_ff;    // address of the read under way
  logic [1:0] cnt_ff;   // exchanges since the command byte
  logic       pol_ff;   // last written polarity select
  logic       allow_ff; // last written edge allow
  logic       en_ff;    // last written edge status enable
  // both halves taken at one edge, which the slave does when idle
  wire wr_go = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  // shadow of the read address, the exchange count and the bits that decide whether an edge may reach irq
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ar_ff, cnt_ff, pol_ff, allow_ff, en_ff} <= 13'h0;
    end else begin
      if (axi_req.arvalid && axi_rsp.arready) ar_ff <= axi_req.araddr;
      // bit 6 is the allow, bit 5 the polarity select
      if (wr_go && axi_req.awaddr == 8'h20) {allow_ff, pol_ff} <= axi_req.wdata[6:5];
      if (wr_go && axi_req.awaddr == 8'h44) en_ff <= axi_req.wdata[0];
      // a command byte only opens a sequence from idle or the last slot
      if (xfer_valid) cnt_ff <= (xfer_byte_in == 8'h40 && (cnt_ff == 2'h0 || cnt_ff == 2'h3)) ? 2'h1 :
                                (cnt_ff == 2'h0) ? 2'h0 : cnt_ff + 2'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_edge_seen;
    en_ff && allow_ff && $past(edge_sense_pin) == pol_ff && edge_sense_pin != pol_ff;
  endsequence
  sequence s_rd_first;
    $rose(axi_rsp.rvalid);
  endsequence
  a_reset_pins_low: assert property ($rose(aresetn) |-> pin_level_bits_out == 8'h00)
    else $error("pin outputs not low after reset");
  a_pin_write: assert property (wr_go && axi_req.awaddr == 8'h04 |=> pin_level_bits_out == $past(axi_req.wdata[7:0]))
    else $error("pin outputs do not follow written byte");
  a_pin_read: assert property (s_rd_first ##0 ar_ff == 8'h04 |-> axi_rsp.rdata == {24'h0, $past(pin_level_bits_in, 3)})
    else $error("pin read does not show pin levels");
  a_ctrl_unused: assert property (s_rd_first ##0 ar_ff == 8'h20 |-> axi_rsp.rdata[4:0] == 5'h0 && axi_rsp.rdata[31:8] == 24'h0)
    else $error("unused edge control bits read nonzero");
  a_edge_irq: assert property (s_edge_seen |-> ##[1:5] irq)
    else $error("qualifying edge gave no interrupt");
  a_rev_msb: assert property (xfer_valid && cnt_ff == 2'h1 |=> xfer_byte_out == REV_CODE[15:8])
    else $error("revision high byte not presented after dummy");
  a_rev_lsb: assert property (xfer_valid && cnt_ff == 2'h2 |=> xfer_byte_out == REV_CODE[7:0])
    else $error("revision low byte not presented second");
  a_rev_idle: assert property (xfer_valid && (cnt_ff == 2'h0 || cnt_ff == 2'h3) |=> xfer_byte_out == 8'h00)
    else $error("reply byte not zero outside sequence");
endmodule : gsei_monitor
bind gsei_top gsei_monitor #(.REV_CODE(REV_CODE)) u_mon (.aclk, .aresetn, .axi_req, .axi_rsp, .pin_level_bits_in,
  .pin_level_bits_out, .edge_sense_pin, .xfer_valid, .xfer_byte_in, .xfer_byte_out, .irq);

// >>> tb/gsei_host.sv
`timescale 1ns/1ps
// serial master model: one full-duplex byte exchange per xchg call, four per rev_read call
module gsei_host (
  input  wire logic       aclk,
  input  wire logic [7:0] xfer_byte_out,
  output logic            xfer_valid,
  output logic      [7:0] xfer_byte_in
);
  initial begin
    xfer_valid = 1'b0;
    xfer_byte_in = 8'h00;
  end
  // the byte shifted back is the one presented before this exchange
  task automatic xchg(input logic [7:0] b, output logic [7:0] r);
    xfer_valid <= 1'b1;
    xfer_byte_in <= b;
    r = xfer_byte_out;
    @(posedge aclk);
    xfer_valid <= 1'b0;
    xfer_byte_in <= ~b; // idle line never keeps the last byte
    @(posedge aclk);
  endtask : xchg
  // command, exactly one dummy, then the two reply bytes
  task automatic rev_read(output logic [15:0] v);
    logic [7:0] d;
    xchg(8'h40, d);
    xchg(8'h5A, d);
    xchg(8'h00, v[15:8]);
    xchg(8'h00, v[7:0]);
  endtask : rev_read
endmodule : gsei_host

// >>> tb/test_gsei_top.sv
`timescale 1ns/1ps
// bus, edge and revision checks through the register tasks and host model
module test_gsei_top;
  localparam logic [15:0] REV = 16'h0210; // arbitrary revision value
  logic                    aclk, aresetn, edge_sense_pin, irq, xfer_valid;
  logic [7:0]              pins_in, pins_out, xin, xout;
  gsei_pkg::gsei_axi_req_t req;
  gsei_pkg::gsei_axi_rsp_t rsp;
  int                      n_fail, checks_done, cyc;
  logic [31:0]             d;
  logic [1:0]              r;
  logic [15:0]             v;
  gsei_top #(.REV_CODE(REV)) u_dut (.aclk, .aresetn, .axi_req(req), .axi_rsp(rsp), .pin_level_bits_in(pins_in),
    .pin_level_bits_out(pins_out), .edge_sense_pin, .xfer_valid, .xfer_byte_in(xin), .xfer_byte_out(xout), .irq);
  gsei_host u_host (.aclk, .xfer_byte_out(xout), .xfer_valid, .xfer_byte_in(xin));
  initial aclk = 1'b0;
  always #50 aclk = ~aclk;
  // watchdog: the sequence needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      $display("FAIL %0t watchdog ceiling reached", $time);
      stop_test();
    end
  end
  task automatic stop_test();
    if (n_fail == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] w, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= w;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) begin
        done = 1'b1;
        resp = rsp.bresp;
        req.bready <= 1'b0;
      end
    end
    // let an edge pass so a following call never reassigns bready in this step
    @(posedge aclk);
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) begin
        done = 1'b1;
        dat = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
      end
    end
    // let an edge pass so a following call never reassigns rready in this step
    @(posedge aclk);
  endtask : axr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axr(a, d, r);
    chk(d, e);
    // every address read through here is a mapped register
    chk({30'h0, r}, {30'h0, gsei_pkg::RESP_OKAY});
  endtask : rd_chk
  // fresh status and control, one pin move, then irq and control readback
  task automatic edge_case(input logic [7:0] c, input logic p, input logic ei, input logic [7:0] ec);
    axw(8'h48, 32'h3, r);
    axw(8'h20, {24'h0, c}, r);
    edge_sense_pin <= p;
    repeat (6) @(posedge aclk);
    chk({31'h0, irq}, {31'h0, ei});
    rd_chk(8'h20, {24'h0, ec});
  endtask : edge_case
  initial begin
    {n_fail, checks_done, cyc} = '0;
    aresetn = 1'b0;
    req = '0;
    pins_in = 8'h3C;
    edge_sense_pin = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // the pin synchronisers need two edges before a read shows the pins
    repeat (3) @(posedge aclk);
    chk({24'h0, pins_out}, 32'h0);
    rd_chk(8'h04, 32'h3C);
    rd_chk(8'h20, 32'h0);
    axw(8'h04, 32'hFFFF_FFA5, r);
    chk({30'h0, r}, {30'h0, gsei_pkg::RESP_OKAY});
    chk({24'h0, pins_out}, 32'hA5);
    pins_in <= 8'h5A;
    repeat (4) @(posedge aclk);
    rd_chk(8'h04, 32'h5A);
    axw(8'h20, 32'h1F, r);
    rd_chk(8'h20, 32'h0);
    axw(8'h44, 32'h1, r);
    edge_case(8'h00, 1'b1, 1'b0, 8'h80);
    edge_case(8'h40, 1'b0, 1'b0, 8'h40);
    edge_case(8'h40, 1'b1, 1'b1, 8'hC0);
    edge_case(8'h60, 1'b0, 1'b1, 8'hE0);
    edge_case(8'h60, 1'b1, 1'b0, 8'h60);
    axw(8'h44, 32'h3, r);
    u_host.rev_read(v);
    chk({16'h0, v}, {16'h0, REV});
    u_host.rev_read(v);
    chk({16'h0, v}, {16'h0, REV});
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    rd_chk(8'h40, 32'h2);
    axw(8'h44, 32'h1, r);
    chk({31'h0, irq}, 32'h0);
    axw(8'h48, 32'h2, r);
    rd_chk(8'h40, 32'h0);
    rd_chk(8'h48, 32'h0);
    axr(8'h0C, d, r);
    chk({30'h0, r}, {30'h0, gsei_pkg::RESP_DECERR});
    // a write to a hole is refused and leaves the pins alone
    axw(8'h0C, 32'h0000_00FF, r);
    chk({30'h0, r}, {30'h0, gsei_pkg::RESP_DECERR});
    chk({24'h0, pins_out}, 32'hA5);
    stop_test();
  end
endmodule : test_gsei_top
